// File: tb.sv
`timescale 1ns/1ps
module tb;
  import tcs_pkg::*;
  logic clk = 0;
  logic arst_n = 0;
  logic master_clear = 0;
  logic init_cmd = 0;
  logic bus_test_fail = 0;
  logic write_cmd = 0;
  logic permit_ring = 1;
  logic status1_read = 0;
  logic [3:0] basic_fail = '0;
  logic [3:0] port_active = 4'hf;
  logic [3:0] port_fail = '0;
  logic [7:0] fw_revision = 8'h23;
  logic [7:0] go_code = 8'h5a;
  logic [7:0] mem_module_addr = 8'h3c;
  logic [7:0] expr = 8'hff;
  tcs_fc_type fc;
  tcs_reply_type reply;
  logic [7:0] selftest_result_byte;
  logic led_on;
  logic busy;
  logic write_go;
  logic [15:0] status_word1;
  logic [15:0] q[$];
  int fail_count = 0;
  int checked = 0;
  int i;
  // --
  // clock, partner, design
  // --
  always #12.5 clk = ~clk;
  tcs_host_model host_u (.clk(clk), .fc(fc));
  tcs_selftest dut_u (
    .clk(clk),
    .arst_n(arst_n),
    .master_clear(master_clear),
    .init_cmd(init_cmd),
    .basic_fail(basic_fail),
    .bus_test_fail(bus_test_fail),
    .port_active(port_active),
    .port_fail(port_fail),
    .fc(fc),
    .fw_revision(fw_revision),
    .go_code(go_code),
    .mem_module_addr(mem_module_addr),
    .write_cmd(write_cmd),
    .permit_ring(permit_ring),
    .status1_read(status1_read),
    .reply(reply),
    .selftest_result_byte(selftest_result_byte),
    .led_on(led_on),
    .busy(busy),
    .write_go(write_go),
    .status_word1(status_word1)
  );
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge clk) begin
    if (reply.valid === 1'b1) begin
      if (q.size() == 0) chk("reply_extra", 16'h1, 16'h0);
      else chk("reply", reply.data, q.pop_front());
    end
  end
  task run(input logic [3:0] bf, input logic bus, input logic [3:0] pf, input logic [3:0] pa);
    @(posedge clk);
    basic_fail <= bf;
    bus_test_fail <= bus;
    port_fail <= pf;
    port_active <= pa;
    init_cmd <= 1'b1;
    @(posedge clk) init_cmd <= 1'b0;
    expr = 8'hff;
    if (bf != 0) expr = 8'h00;
    else begin
      if (bus) expr = 8'hf0;
      for (i = 0; i < 4; i++) if (pf[i] && pa[i]) expr[7-i] = 1'b0;
    end
    @(negedge clk) chk("busy", busy, 1);
    for (i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
    chk("done", busy, 0);
    if (busy !== 1'b0) test_done();
    chk("result", selftest_result_byte, expr);
    chk("led", led_on, expr != 8'hff);
  endtask
  // --
  // sequence
  // --
  initial begin
    void'($urandom(37336));
    repeat (10) @(posedge clk);
    chk("rst_result", selftest_result_byte, 8'hff);
    chk("rst_led", {led_on, busy}, 0);
    arst_n <= 1'b1;
    run(0, 0, 0, 4'hf);
    run(4'h2, 0, 4'h5, 4'hf);
    run(0, 1, 0, 4'hf);
    run(0, 0, 4'ha, 4'hf);
    run(0, 0, 4'hf, 4'h5);
    repeat (6) run(($urandom % 3 == 0) ? 4'($urandom) : 4'h0, 1'($urandom), 4'($urandom), 4'($urandom));
    q.push_back({go_code, fw_revision});
    host_u.send(TCS_FC_REVISION);
    q.push_back({mem_module_addr, expr});
    host_u.send(TCS_FC_RESULT);
    host_u.send(6'h20);
    @(posedge clk) permit_ring <= 1'b0;
    write_cmd <= 1'b1;
    @(posedge clk) write_cmd <= 1'b0;
    @(negedge clk) chk("wp", {status_word1[11], write_go}, 2);
    repeat (5) @(negedge clk);
    chk("wp_hold", status_word1[11], 1);
    @(posedge clk) status1_read <= 1'b1;
    @(posedge clk) status1_read <= 1'b0;
    @(negedge clk) chk("wp_clr", status_word1[11], 0);
    @(posedge clk) permit_ring <= 1'b1;
    write_cmd <= 1'b1;
    @(posedge clk) write_cmd <= 1'b0;
    @(negedge clk) chk("go", write_go, 1);
    @(posedge clk) master_clear <= 1'b1;
    basic_fail <= '0;
    bus_test_fail <= 1'b0;
    port_fail <= '0;
    for (i = 0; i < 8 && busy !== 1'b1; i++) @(negedge clk);
    chk("mc_busy", busy, 1);
    @(posedge clk) master_clear <= 1'b0;
    for (i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
    chk("mc_result", {busy, selftest_result_byte}, 16'hff);
    @(posedge clk) init_cmd <= 1'b1;
    @(posedge clk) init_cmd <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk) chk("mid_rst", {busy, led_on, selftest_result_byte}, 16'h00ff);
    @(posedge clk) arst_n <= 1'b1;
    run(0, 0, 0, 4'hf);
    chk("pending", q.size(), 0);
    test_done();
  end
endmodule

// File: tcs_host_model.sv
`timescale 1ns/1ps
module tcs_host_model
  import tcs_pkg::*;
(
  input wire logic clk,
  output tcs_pkg::tcs_fc_type fc
);
  // --
  // function code strobe, one cycle
  // --
  initial fc = '0;
  task automatic send(input logic [5:0] code);
    @(posedge clk) fc <= '{code: code, valid: 1'b1};
    @(posedge clk) fc.valid <= 1'b0;
  endtask
endmodule

// File: tcs_pkg.sv
//
// Notes on behaviour
// - bus master clear or initialize control word starts the quick logic self-test.
// - indicator lit throughout self-test, turned off only on full success.
// - initialize loads the result byte with ff before any subtest.
// - any basic controller subtest failure writes 00 into the result byte.
// - all basic controller subtests passing writes ff into the result byte.
// - bus self-test failure clears result bits 4 to 7 as one group.
// - adapter tests clear result bit n for each active failing port n.
// - after both tests, indicator off if result is ff, else stays on.
// - function code 04 returns firmware revision low byte, go code high byte.
// - function code 0a returns result byte low, memory module address high.
// - write to drive without permit ring is inhibited and flagged in status word 1 bit 11.
// - detected errors stay held in status registers until the host reads them.
//
package tcs_pkg;

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam logic [7:0] TCS_RESULT_RESET = 8'hff;
  localparam logic [7:0] TCS_RESULT_PASS = 8'hff;
  localparam logic [7:0] TCS_RESULT_BASIC_FAIL = 8'h00;
  localparam logic [7:0] TCS_BUS_FAIL_MASK = 8'hf0;
  localparam logic [5:0] TCS_FC_REVISION = 6'h04;
  localparam logic [5:0] TCS_FC_RESULT = 6'h0a;
  localparam int TCS_WPROT_BIT = 11;
  localparam int TCS_NPORTS = 4;
  localparam int TCS_BASIC_STEPS = 4;
  localparam logic [2:0] TCS_STEP_LAST = 3'h3;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    TCS_IDLE,
    TCS_BASIC,
    TCS_BUS,
    TCS_WAIT_FC,
    TCS_ADAPTER,
    TCS_DONE
  } tcs_state_type;

  typedef struct packed {
    logic [5:0] code;
    logic valid;
  } tcs_fc_type;

  typedef struct packed {
    logic [15:0] data;
    logic valid;
  } tcs_reply_type;

endpackage

// File: tcs_reply.sv
`timescale 1ns/1ps
module tcs_reply (
  input wire logic clk,
  input wire logic arst_n,
  input tcs_pkg::tcs_fc_type fc,
  input wire logic [7:0] result,
  input wire logic [7:0] fw_revision,
  input wire logic [7:0] go_code,
  input wire logic [7:0] mem_module_addr,
  output tcs_pkg::tcs_reply_type reply
);
  import tcs_pkg::*;

  typedef struct packed {
    tcs_reply_type r;
  } tcs_reply_state_type;

  tcs_reply_state_type st_q;
  tcs_reply_state_type st_d;

  // ----------------------------------------
  // diagnostic function code answers
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.r.valid = 1'b0;
    if (fc.valid) begin
      if (fc.code == TCS_FC_REVISION) begin
        st_d.r.data = {go_code, fw_revision};
        st_d.r.valid = 1'b1;
      end else if (fc.code == TCS_FC_RESULT) begin
        st_d.r.data = {mem_module_addr, result};
        st_d.r.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reply = st_q.r;
endmodule

// File: tcs_selftest.sv
`timescale 1ns/1ps
module tcs_selftest (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic master_clear,
  input wire logic init_cmd,
  input wire logic [3:0] basic_fail,
  input wire logic bus_test_fail,
  input wire logic [3:0] port_active,
  input wire logic [3:0] port_fail,
  input tcs_pkg::tcs_fc_type fc,
  input wire logic [7:0] fw_revision,
  input wire logic [7:0] go_code,
  input wire logic [7:0] mem_module_addr,
  input wire logic write_cmd,
  input wire logic permit_ring,
  input wire logic status1_read,
  output tcs_pkg::tcs_reply_type reply,
  output logic [7:0] selftest_result_byte,
  output logic led_on,
  output logic busy,
  output logic write_go,
  output logic [15:0] status_word1
);
  import tcs_pkg::*;

  typedef struct packed {
    tcs_state_type state;
    logic [2:0] step;
    logic [3:0] port;
    logic [7:0] result;
    logic led;
    logic busy;
    logic write_go;
    logic [15:0] status1;
    logic mclr_prev;
  } tcs_top_state_type;

  tcs_top_state_type st_q;
  tcs_top_state_type st_d;
  logic mclr_s;
  logic start;
  logic [7:0] port_mask;

  // ----------------------------------------
  // pin samplers
  // ----------------------------------------
  tcs_sync u_mclr_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(master_clear),
    .dout(mclr_s)
  );

  assign start = (mclr_s && !st_q.mclr_prev) || init_cmd;

  // ----------------------------------------
  // port bit map, bit 0 is the msb of the byte
  // ----------------------------------------
  always_comb begin
    port_mask = 8'hff;
    for (int i = 0; i < TCS_NPORTS; i++) begin
      if (st_q.port[i] && port_active[i] && port_fail[i]) begin
        port_mask[7 - i] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // self-test sequencer and status
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.write_go = 1'b0;
    st_d.mclr_prev = mclr_s;
    case (st_q.state)
      TCS_IDLE: begin
      end
      TCS_BASIC: begin
        if (basic_fail[st_q.step[1:0]]) begin
          st_d.result = TCS_RESULT_BASIC_FAIL;
          st_d.state = TCS_DONE;
        end else if (st_q.step == TCS_STEP_LAST) begin
          st_d.result = TCS_RESULT_PASS;
          st_d.state = TCS_BUS;
        end else begin
          st_d.step = st_q.step + 3'h1;
        end
      end
      TCS_BUS: begin
        if (bus_test_fail) begin
          st_d.result = st_q.result & TCS_BUS_FAIL_MASK;
        end
        st_d.state = TCS_WAIT_FC;
      end
      TCS_WAIT_FC: begin
        st_d.port = 4'h1;
        st_d.state = TCS_ADAPTER;
      end
      TCS_ADAPTER: begin
        st_d.result = st_q.result & port_mask;
        st_d.port = {st_q.port[2:0], 1'b0};
        if (st_q.port[TCS_NPORTS - 1]) begin
          st_d.state = TCS_DONE;
        end
      end
      TCS_DONE: begin
        st_d.led = (st_q.result != TCS_RESULT_PASS);
        st_d.busy = 1'b0;
        st_d.state = TCS_IDLE;
      end
      default: begin
        st_d.state = TCS_IDLE;
      end
    endcase
    if (start) begin
      st_d.state = TCS_BASIC;
      st_d.step = 3'h0;
      st_d.port = 4'h0;
      st_d.result = TCS_RESULT_RESET;
      st_d.led = 1'b1;
      st_d.busy = 1'b1;
    end
    if (status1_read) begin
      st_d.status1[TCS_WPROT_BIT] = 1'b0;
    end
    if (write_cmd) begin
      if (!permit_ring) begin
        st_d.status1[TCS_WPROT_BIT] = 1'b1;
      end else begin
        st_d.write_go = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q.state <= TCS_IDLE;
      st_q.step <= 3'h0;
      st_q.port <= 4'h0;
      st_q.result <= TCS_RESULT_RESET;
      st_q.led <= 1'b0;
      st_q.busy <= 1'b0;
      st_q.write_go <= 1'b0;
      st_q.status1 <= 16'h0000;
      st_q.mclr_prev <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // diagnostic replies
  // ----------------------------------------
  tcs_reply u_reply (
    .clk(clk),
    .arst_n(arst_n),
    .fc(fc),
    .result(st_q.result),
    .fw_revision(fw_revision),
    .go_code(go_code),
    .mem_module_addr(mem_module_addr),
    .reply(reply)
  );

  assign selftest_result_byte = st_q.result;
  assign led_on = st_q.led;
  assign busy = st_q.busy;
  assign write_go = st_q.write_go;
  assign status_word1 = st_q.status1;
endmodule

// File: tcs_selftest_props.sv
`timescale 1ns/1ps
module tcs_selftest_props
  import tcs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic init_cmd,
  input tcs_pkg::tcs_fc_type fc,
  input wire logic [7:0] fw_revision,
  input wire logic [7:0] go_code,
  input wire logic [7:0] mem_module_addr,
  input wire logic write_cmd,
  input wire logic permit_ring,
  input wire logic status1_read,
  input tcs_pkg::tcs_reply_type reply,
  input wire logic [7:0] selftest_result_byte,
  input wire logic led_on,
  input wire logic busy,
  input wire logic write_go,
  input wire logic [15:0] status_word1
);
  // --
  // checks
  // --
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_rev;
    fc.valid && fc.code == TCS_FC_REVISION;
  endsequence
  sequence s_res;
    fc.valid && fc.code == TCS_FC_RESULT;
  endsequence
  a_start_busy: assert property (init_cmd |=> busy && led_on && selftest_result_byte == 8'hff)
    else $error("no start");
  a_led_busy: assert property (busy |-> led_on)
    else $error("led off in test");
  a_led_end: assert property ($fell(busy) |-> led_on == (selftest_result_byte != 8'hff))
    else $error("led at end");
  a_rev_reply: assert property (s_rev |=> reply.valid && reply.data == {$past(go_code), $past(fw_revision)})
    else $error("rev reply");
  a_res_reply: assert property (s_res |=> reply.valid
    && reply.data == {$past(mem_module_addr), $past(selftest_result_byte)})
    else $error("result reply");
  a_no_reply: assert property (!(fc.valid && (fc.code == TCS_FC_REVISION || fc.code == TCS_FC_RESULT))
    |=> !reply.valid)
    else $error("stray reply");
  a_wp_flag: assert property (write_cmd && !permit_ring |=> status_word1[TCS_WPROT_BIT])
    else $error("no protect flag");
  a_wp_hold: assert property (status_word1[TCS_WPROT_BIT] && !status1_read |=> status_word1[TCS_WPROT_BIT])
    else $error("flag lost");
  a_write_go: assert property (write_cmd |=> write_go == $past(permit_ring))
    else $error("write go wrong");
  a_wp_clear: assert property (status1_read && !write_cmd |=> !status_word1[TCS_WPROT_BIT])
    else $error("flag not cleared");
endmodule
bind tcs_selftest tcs_selftest_props props_u (
  .clk(clk),
  .arst_n(arst_n),
  .init_cmd(init_cmd),
  .fc(fc),
  .fw_revision(fw_revision),
  .go_code(go_code),
  .mem_module_addr(mem_module_addr),
  .write_cmd(write_cmd),
  .permit_ring(permit_ring),
  .status1_read(status1_read),
  .reply(reply),
  .selftest_result_byte(selftest_result_byte),
  .led_on(led_on),
  .busy(busy),
  .write_go(write_go),
  .status_word1(status_word1)
);

// File: tcs_sync.sv
`timescale 1ns/1ps
module tcs_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  import tcs_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } tcs_sync_state_type;

  tcs_sync_state_type st_q;
  tcs_sync_state_type st_d;

  // ----------------------------------------
  // three stage sampler, change taken once stages 2 and 3 agree
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.out = st_q.s3;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.out;
endmodule
